// ### cse_pkg.sv
// Purpose: shared constants and types for the instruction subset execution block
// Assumes: one instruction cycle per core_clk cycle
// Notes: register offsets index the plain register port
package cse_pkg;

  // widths
  localparam int PC_W = 15;
  localparam int WORD_W = 14;
  localparam int FADDR_W = 7;
  localparam int REG_ADDR_W = 4;

  // opcode encodings of the supported instructions
  localparam logic [13:0] OPC_WDOG_CLEAR = 14'h0064;
  localparam logic [13:0] OPC_CALL_WORK = 14'h000A;
  localparam logic [13:0] OPC_CLR_WORK_VAL = 14'h0100;
  localparam logic [13:0] OPC_CLR_WORK_MASK = 14'h3FFC;
  localparam logic [6:0] OPC_CLR_FILE_HI = 7'h03;
  localparam logic [5:0] OPC_CPL_FILE_HI = 6'h09;
  localparam logic [5:0] OPC_DEC_FILE_HI = 6'h03;

  // operand field positions
  localparam int DEST_POS = 7;

  // register offsets on the software port
  localparam logic [3:0] OFS_WREG = 4'h0;
  localparam logic [3:0] OFS_PCLATCH = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_PC_LO = 4'h3;
  localparam logic [3:0] OFS_PC_HI = 4'h4;
  localparam logic [3:0] OFS_WDT_CNT = 4'h5;
  localparam logic [3:0] OFS_STK_LVL = 4'h6;
  localparam logic [3:0] OFS_FPTR = 4'h7;
  localparam logic [3:0] OFS_FDATA = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'h9;
  localparam logic [3:0] OFS_TOS_LO = 4'hA;
  localparam logic [3:0] OFS_TOS_HI = 4'hB;

  // status and control bit positions
  localparam int ST_TO_POS = 4;
  localparam int ST_PDOWN_POS = 3;
  localparam int ST_Z_POS = 2;
  localparam int CTRL_WDT_EN_POS = 0;

  // reset values
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [6:0] PCLATCH_RST = 7'h00;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic TO_RST = 1'b1;
  localparam logic PDOWN_RST = 1'b1;
  localparam logic Z_RST = 1'b0;
  localparam logic WDT_EN_RST = 1'b1;

  // watchdog and stack sizes
  localparam int WDT_PRESC_W = 8;
  localparam int WDT_CNT_W = 8;
  localparam int STK_DEPTH = 16;
  localparam int STK_PTR_W = 4;

  typedef enum logic [2:0] {
    CSE_OP_NOP, CSE_OP_WDOG_CLEAR, CSE_OP_CALL_WORK, CSE_OP_CPL_FILE, CSE_OP_CLR_FILE, CSE_OP_CLR_WORK,
    CSE_OP_DEC_FILE
  } cse_op_t;

  typedef enum logic {CSE_ST_EXEC, CSE_ST_CALL2} cse_state_t;

  typedef struct packed {
    cse_op_t op;
    logic dest;
    logic [6:0] faddr;
  } cse_instr_t;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } cse_instr_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cse_reg_req_t;

endpackage

// ### cse_watchdog.sv
// Purpose: watchdog prescaler and counter with synchronous clear
// Assumes: clear beats counting in the same cycle
// Notes: expire_q is a one-cycle pulse when the counter wraps
`timescale 1ns/1ps
module cse_watchdog (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic clear,
  output logic [7:0] presc_q,
  output logic [7:0] count_q,
  output logic expire_q
);
  wire presc_wrap = (presc_q == 8'hFF);
  wire count_wrap = (count_q == 8'hFF);

  // clear zeroes both stages, so a pending wrap in that cycle is dropped
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      presc_q <= 8'h00;
      count_q <= 8'h00;
      expire_q <= 1'b0;
    end
    else if (clear)
    begin
      presc_q <= 8'h00;
      count_q <= 8'h00;
      expire_q <= 1'b0;
    end
    else
    begin
      presc_q <= enable ? 8'(presc_q + 8'h01) : presc_q;
      count_q <= (enable && presc_wrap) ? 8'(count_q + 8'h01) : count_q;
      expire_q <= enable && presc_wrap && count_wrap;
    end
  end
endmodule

// ### cse_ret_stack.sv
// Purpose: circular return address stack
// Assumes: sixteen entries; a push past the top overwrites the oldest
// Notes: level saturates at the depth
`timescale 1ns/1ps
module cse_ret_stack (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [14:0] push_data,
  output logic [14:0] top,
  output logic [4:0] level_q
);
  logic [14:0] stk_mem [0:cse_pkg::STK_DEPTH-1];
  logic [3:0] ptr_q;

  // top is the entry just below the write pointer
  assign top = stk_mem[4'(ptr_q - 4'h1)];

  always_ff @(posedge core_clk)
  begin
    if (push)
      stk_mem[ptr_q] <= push_data;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_q <= 4'h0;
      level_q <= 5'h00;
    end
    else if (push)
    begin
      ptr_q <= 4'(ptr_q + 4'h1);
      level_q <= (level_q == 5'h10) ? level_q : 5'(level_q + 5'h01);
    end
  end
endmodule

// ### cse_core.sv
// Purpose: executes watchdog clear, call via working register, complement, clear, clear working and decrement
// Assumes: one instruction per core_clk cycle, two for the call; software reaches state over a plain register port
// Notes: an instruction and a software write to the same target in one cycle: the instruction wins
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module cse_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire cse_pkg::cse_instr_req_t instr_req,
  input wire cse_pkg::cse_reg_req_t reg_req,
  output logic instr_ready_q,
  output logic [7:0] reg_rdata_q,
  output logic [14:0] program_counter_q,
  output logic wdt_expired_q
);
  logic [7:0] wreg_q;
  logic [7:0] wreg_d;
  logic [6:0] pclatch_q;
  logic [6:0] fptr_q;
  logic z_q;
  logic z_d;
  logic timeout_flag_q;
  logic timeout_flag_d;
  logic powerdown_flag_q;
  logic powerdown_flag_d;
  logic wdt_en_q;
  logic [14:0] program_counter_d;
  logic [7:0] rdata_d;
  logic [7:0] file_mem [0:127];
  cse_pkg::cse_state_t state_q;
  cse_pkg::cse_state_t state_d;
  cse_pkg::cse_instr_t dec;
  logic [7:0] wdt_presc;
  logic [7:0] wdt_count;
  logic wdt_expire;
  logic [14:0] top_of_stack;
  logic [4:0] stk_level;

  // instruction decode; anything not in the subset runs as a no-op
  wire [13:0] iw = instr_req.word;
  assign dec.dest = iw[cse_pkg::DEST_POS];
  assign dec.faddr = iw[6:0];
  assign dec.op = (iw == cse_pkg::OPC_WDOG_CLEAR) ? cse_pkg::CSE_OP_WDOG_CLEAR :
                  (iw == cse_pkg::OPC_CALL_WORK) ? cse_pkg::CSE_OP_CALL_WORK :
                  ((iw & cse_pkg::OPC_CLR_WORK_MASK) == cse_pkg::OPC_CLR_WORK_VAL) ? cse_pkg::CSE_OP_CLR_WORK :
                  (iw[13:7] == cse_pkg::OPC_CLR_FILE_HI) ? cse_pkg::CSE_OP_CLR_FILE :
                  (iw[13:8] == cse_pkg::OPC_CPL_FILE_HI) ? cse_pkg::CSE_OP_CPL_FILE :
                  (iw[13:8] == cse_pkg::OPC_DEC_FILE_HI) ? cse_pkg::CSE_OP_DEC_FILE : cse_pkg::CSE_OP_NOP;

  // an instruction is taken only while ready, which drops for the second call cycle
  wire take = instr_req.valid && instr_ready_q;
  wire take_wdog_clear = take && (dec.op == cse_pkg::CSE_OP_WDOG_CLEAR);
  wire take_call_work = take && (dec.op == cse_pkg::CSE_OP_CALL_WORK);
  wire take_cpl = take && (dec.op == cse_pkg::CSE_OP_CPL_FILE);
  wire take_clr_file = take && (dec.op == cse_pkg::CSE_OP_CLR_FILE);
  wire take_clr_work = take && (dec.op == cse_pkg::CSE_OP_CLR_WORK);
  wire take_dec = take && (dec.op == cse_pkg::CSE_OP_DEC_FILE);
  wire take_alu = take_cpl || take_dec;

  // arithmetic on the addressed file register
  wire [7:0] f_val = file_mem[dec.faddr];
  wire [7:0] cpl_res = ~f_val;
  wire [7:0] dec_res = 8'(f_val - 8'h01);
  wire [7:0] alu_res = take_dec ? dec_res : cpl_res;
  wire alu_zero = (alu_res == 8'h00);

  // software port decode
  wire bus_wr_wreg = reg_req.wr && (reg_req.addr == cse_pkg::OFS_WREG);
  wire bus_wr_pcl = reg_req.wr && (reg_req.addr == cse_pkg::OFS_PCLATCH);
  wire bus_wr_stat = reg_req.wr && (reg_req.addr == cse_pkg::OFS_STATUS);
  wire bus_wr_fptr = reg_req.wr && (reg_req.addr == cse_pkg::OFS_FPTR);
  wire bus_wr_fdata = reg_req.wr && (reg_req.addr == cse_pkg::OFS_FDATA);
  wire bus_wr_ctrl = reg_req.wr && (reg_req.addr == cse_pkg::OFS_CTRL);

  // single file write port; the destination bit steers the result
  wire instr_mem_we = take_clr_file || (take_alu && dec.dest);
  wire mem_we = instr_mem_we || bus_wr_fdata;
  wire [6:0] mem_addr = instr_mem_we ? dec.faddr : fptr_q;
  wire [7:0] mem_wdata = take_clr_file ? 8'h00 : (instr_mem_we ? alu_res : reg_req.wdata);

  // working register: instruction results first, then software
  wire instr_wreg_we = take_clr_work || (take_alu && !dec.dest);
  assign wreg_d = take_clr_work ? 8'h00 :
                  instr_wreg_we ? alu_res :
                  bus_wr_wreg ? reg_req.wdata : wreg_q;

  // zero flag; the call and watchdog clear never touch it
  assign z_d = (take_clr_file || take_clr_work) ? 1'b1 :
               take_alu ? alu_zero :
               bus_wr_stat ? reg_req.wdata[cse_pkg::ST_Z_POS] : z_q;

  // a watchdog expiry in the same cycle as a clear still shows, so it is never lost
  assign timeout_flag_d = wdt_expire ? 1'b0 : (take_wdog_clear ? 1'b1 : timeout_flag_q);
  assign powerdown_flag_d = take_wdog_clear ? 1'b1 : powerdown_flag_q;

  // program counter: the call jumps at once, the second cycle only holds
  wire [14:0] pc_next = 15'(program_counter_q + 15'h0001);
  assign program_counter_d = take_call_work ? {pclatch_q, wreg_q} :
                             take ? pc_next : program_counter_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      cse_pkg::CSE_ST_EXEC:
        if (take_call_work)
          state_d = cse_pkg::CSE_ST_CALL2;
      cse_pkg::CSE_ST_CALL2:
        state_d = cse_pkg::CSE_ST_EXEC;
      default:
        state_d = cse_pkg::CSE_ST_EXEC;
    endcase
  end

  // read mux; unmapped offsets and idle cycles read as zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        cse_pkg::OFS_WREG: rdata_d = wreg_q;
        cse_pkg::OFS_PCLATCH: rdata_d = {1'b0, pclatch_q};
        cse_pkg::OFS_STATUS: rdata_d = {3'h0, timeout_flag_q, powerdown_flag_q, z_q, 2'h0};
        cse_pkg::OFS_PC_LO: rdata_d = program_counter_q[7:0];
        cse_pkg::OFS_PC_HI: rdata_d = {1'b0, program_counter_q[14:8]};
        cse_pkg::OFS_WDT_CNT: rdata_d = wdt_count;
        cse_pkg::OFS_STK_LVL: rdata_d = {3'h0, stk_level};
        cse_pkg::OFS_FPTR: rdata_d = {1'b0, fptr_q};
        cse_pkg::OFS_FDATA: rdata_d = file_mem[fptr_q];
        cse_pkg::OFS_CTRL: rdata_d = {7'h00, wdt_en_q};
        cse_pkg::OFS_TOS_LO: rdata_d = top_of_stack[7:0];
        cse_pkg::OFS_TOS_HI: rdata_d = {1'b0, top_of_stack[14:8]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // watchdog clear zeroes counter and prescaler
  cse_watchdog u_wdt (
    .core_clk(core_clk),
    .rst(rst),
    .enable(wdt_en_q),
    .clear(take_wdog_clear),
    .presc_q(wdt_presc),
    .count_q(wdt_count),
    .expire_q(wdt_expire)
  );

  // return address of the call
  cse_ret_stack u_stack (
    .core_clk(core_clk),
    .rst(rst),
    .push(take_call_work),
    .push_data(pc_next),
    .top(top_of_stack),
    .level_q(stk_level)
  );

  // file register array has no reset; contents are undefined until written
  always_ff @(posedge core_clk)
  begin
    if (mem_we)
      file_mem[mem_addr] <= mem_wdata;
  end

  // core state registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wreg_q <= cse_pkg::WREG_RST;
      z_q <= cse_pkg::Z_RST;
      timeout_flag_q <= cse_pkg::TO_RST;
      powerdown_flag_q <= cse_pkg::PDOWN_RST;
      program_counter_q <= cse_pkg::PC_RST;
      state_q <= cse_pkg::CSE_ST_EXEC;
      instr_ready_q <= 1'b1;
    end
    else
    begin
      wreg_q <= wreg_d;
      z_q <= z_d;
      timeout_flag_q <= timeout_flag_d;
      powerdown_flag_q <= powerdown_flag_d;
      program_counter_q <= program_counter_d;
      state_q <= state_d;
      instr_ready_q <= !take_call_work;
    end
  end

  // software-only registers and port outputs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pclatch_q <= cse_pkg::PCLATCH_RST;
      fptr_q <= 7'h00;
      wdt_en_q <= cse_pkg::WDT_EN_RST;
      reg_rdata_q <= 8'h00;
      wdt_expired_q <= 1'b0;
    end
    else
    begin
      pclatch_q <= bus_wr_pcl ? reg_req.wdata[6:0] : pclatch_q;
      fptr_q <= bus_wr_fptr ? reg_req.wdata[6:0] : fptr_q;
      wdt_en_q <= bus_wr_ctrl ? reg_req.wdata[cse_pkg::CTRL_WDT_EN_POS] : wdt_en_q;
      reg_rdata_q <= rdata_d;
      wdt_expired_q <= wdt_expire;
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_wdt_count_clear: assert property (take_wdog_clear |=> wdt_count == 8'h00)
    else $error("watchdog count not cleared");

  a_wdt_presc_clear: assert property (take_wdog_clear |=> wdt_presc == 8'h00)
    else $error("watchdog prescaler not cleared");

  a_wdog_clear_flags: assert property (take_wdog_clear && !wdt_expire |=>
    timeout_flag_q && powerdown_flag_q && (z_q == $past(z_q)))
    else $error("watchdog clear status wrong");

  a_call_push: assert property (take_call_work |=>
    (top_of_stack == 15'($past(program_counter_q) + 15'h0001)))
    else $error("call return address wrong");

  a_call_target: assert property (take_call_work |=>
    program_counter_q == {$past(pclatch_q), $past(wreg_q)})
    else $error("call target wrong");

  a_call_two_cycle: assert property (take_call_work |=>
    !instr_ready_q && $stable(z_q) && $stable(timeout_flag_q) ##1 instr_ready_q && $stable(program_counter_q))
    else $error("call cycle count or status wrong");

  a_cpl_to_wreg: assert property (take_cpl && !dec.dest |=> wreg_q == ~$past(f_val))
    else $error("complement to working register wrong");

  a_alu_to_file: assert property (take_alu && dec.dest |=>
    file_mem[$past(dec.faddr)] == $past(alu_res) && $stable(wreg_q))
    else $error("file destination write wrong");

  a_clr_file_zero: assert property (take_clr_file |=> file_mem[$past(dec.faddr)] == 8'h00 && z_q)
    else $error("clear file wrong");

  a_clr_work_zero: assert property (take_clr_work |=> wreg_q == 8'h00 && z_q)
    else $error("clear working wrong");

  a_dec_to_wreg: assert property (take_dec && !dec.dest |=>
    wreg_q == 8'($past(f_val) - 8'h01))
    else $error("decrement to working register wrong");

  a_alu_zero_flag: assert property (take_alu |=>
    (z_q == ($past(alu_res) == 8'h00)) && $stable(timeout_flag_q) && $stable(powerdown_flag_q))
    else $error("zero flag wrong");

  c_call_work: cover property (take_call_work ##2 take);
  c_wdog_clear: cover property (take_wdog_clear);
  c_dec_zero: cover property (take_dec && alu_zero);
  c_wdt_expire: cover property (wdt_expire);
endmodule

// ### cse_core_bench.sv
// Purpose: self-checking bench for the instruction subset execution core
// Assumes: register read data stands only in the cycle after the read strobe
// Notes: the watchdog expiry wait takes about 65536 cycles and dominates the run
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("FAIL %s expected %0h seen %0h", name, exp, got); \
    end \
  end

module cse_core_bench;
  logic core_clk;
  logic rst;
  cse_pkg::cse_instr_req_t instr_req;
  cse_pkg::cse_reg_req_t reg_req;
  logic instr_ready_q;
  logic [7:0] reg_rdata_q;
  logic [14:0] program_counter_q;
  logic wdt_expired_q;
  int fails;
  int samples_checked;

  // free-running core clock, 4 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  cse_core i_dut (
    .core_clk(core_clk),
    .rst(rst),
    .instr_req(instr_req),
    .reg_req(reg_req),
    .instr_ready_q(instr_ready_q),
    .reg_rdata_q(reg_rdata_q),
    .program_counter_q(program_counter_q),
    .wdt_expired_q(wdt_expired_q)
  );

  // one-cycle write strobe on the register port
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  // data is sampled just after the edge that ends the strobe, its only valid cycle
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask

  // offer one instruction for a single edge; returns just after the taking edge
  task automatic exec(input logic [13:0] w);
    @(posedge core_clk);
    instr_req.word <= w;
    instr_req.valid <= 1'b1;
    @(posedge core_clk);
    instr_req.valid <= 1'b0;
    #1;
  endtask

  task automatic end_of_test;
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // expected 8-bit result: 0 complement, 1 decrement, else zero
  function automatic logic [7:0] alu_res(input int op, input logic [7:0] v);
    if (op == 0)
      return ~v;
    if (op == 1)
      return v - 8'h01;
    return 8'h00;
  endfunction

  initial
  begin
    logic [7:0] wv, fv, got, res, ew, ef, lvl, lo, hi;
    logic [6:0] f, lv;
    logic d, zv, ez;
    logic [14:0] pc0;
    logic [13:0] w;
    logic [7:0] corner [3];
    int op, n;
    corner = '{8'h01, 8'hFF, 8'h00};
    fails = 0;
    samples_checked = 0;
    instr_req = '0;
    reg_req = '0;
    rst = 1'b1;
    void'($urandom(32'hC045A152));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // reset state seen through the ports
    reg_rd(cse_pkg::OFS_WREG, got);
    `CHK("wreg reset", 8'h00, got)
    reg_rd(cse_pkg::OFS_STATUS, got);
    `CHK("status reset", 3'b110, got[4:2])
    `CHK("ready reset", 1'b1, instr_ready_q)
    // let the watchdog run, then clear it with Z set to see Z survive
    repeat (600) @(posedge core_clk);
    reg_rd(cse_pkg::OFS_WDT_CNT, got);
    `CHK("wdt running", 1'b1, got != 8'h00)
    reg_wr(cse_pkg::OFS_STATUS, 8'h04);
    exec(cse_pkg::OPC_WDOG_CLEAR);
    reg_rd(cse_pkg::OFS_WDT_CNT, got);
    `CHK("wdt cleared", 8'h00, got)
    repeat (200) @(posedge core_clk);
    reg_rd(cse_pkg::OFS_WDT_CNT, got);
    `CHK("wdt prescaler cleared", 8'h00, got)
    // expiry drops the timeout flag; a later clear must raise it again
    n = 0;
    while (wdt_expired_q !== 1'b1 && n < 70000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 70000)
    begin
      fails++;
      end_of_test();
    end
    reg_rd(cse_pkg::OFS_STATUS, got);
    `CHK("status after expiry", 3'b011, got[4:2])
    exec(cse_pkg::OPC_WDOG_CLEAR);
    reg_rd(cse_pkg::OFS_STATUS, got);
    `CHK("status after clear", 3'b111, got[4:2])
    // call via working register, status preset to Z=1
    for (int k = 0; k < 3; k++)
    begin
      wv = $urandom;
      lv = $urandom;
      reg_wr(cse_pkg::OFS_WREG, wv);
      reg_wr(cse_pkg::OFS_PCLATCH, {1'b0, lv});
      reg_wr(cse_pkg::OFS_STATUS, 8'h04);
      reg_rd(cse_pkg::OFS_STK_LVL, lvl);
      pc0 = program_counter_q;
      exec(cse_pkg::OPC_CALL_WORK);
      `CHK("call ready low", 1'b0, instr_ready_q)
      `CHK("call target", {lv, wv}, program_counter_q)
      @(posedge core_clk);
      #1;
      `CHK("call ready back", 1'b1, instr_ready_q)
      `CHK("call pc holds", {lv, wv}, program_counter_q)
      reg_rd(cse_pkg::OFS_TOS_LO, lo);
      reg_rd(cse_pkg::OFS_TOS_HI, hi);
      `CHK("return address", pc0 + 15'h0001, {hi[6:0], lo})
      reg_rd(cse_pkg::OFS_STK_LVL, got);
      `CHK("stack level", lvl + 8'h01, got)
      reg_rd(cse_pkg::OFS_STATUS, got);
      `CHK("call status", 3'b111, got[4:2])
    end
    // file operations: random operands with corner values first
    for (int i = 0; i < 48; i++)
    begin
      op = i % 4;
      f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
      fv = (i < 12) ? corner[i % 3] : 8'($urandom);
      wv = $urandom;
      d = $urandom;
      zv = $urandom;
      reg_wr(cse_pkg::OFS_FPTR, {1'b0, f});
      reg_wr(cse_pkg::OFS_FDATA, fv);
      reg_wr(cse_pkg::OFS_WREG, wv);
      reg_wr(cse_pkg::OFS_STATUS, {5'h00, zv, 2'h0});
      case (op)
        0: w = {cse_pkg::OPC_CPL_FILE_HI, d, f};
        1: w = {cse_pkg::OPC_DEC_FILE_HI, d, f};
        2: w = {cse_pkg::OPC_CLR_FILE_HI, f};
        default: w = cse_pkg::OPC_CLR_WORK_VAL | 14'($urandom % 4);
      endcase
      exec(w);
      res = alu_res(op, fv);
      ew = (op == 3) ? 8'h00 : (op < 2 && !d) ? res : wv;
      ef = (op == 2) ? 8'h00 : (op < 2 && d) ? res : fv;
      ez = (op >= 2) ? 1'b1 : (res == 8'h00);
      reg_rd(cse_pkg::OFS_WREG, got);
      `CHK("wreg result", ew, got)
      reg_rd(cse_pkg::OFS_FDATA, got);
      `CHK("file result", ef, got)
      reg_rd(cse_pkg::OFS_STATUS, got);
      `CHK("zero flag", ez, got[cse_pkg::ST_Z_POS])
      `CHK("other flags", 2'b11, got[4:3])
    end
    end_of_test();
  end
endmodule
